/* rtl/cache_lock_defs.svh */
// Constants for the cache lock/unlock command interpreter
`ifndef CACHE_LOCK_DEFS_SVH
`define CACHE_LOCK_DEFS_SVH
`define CLK_OPCODE        8'h36
`define CLK_CDB_BYTES     4'ha
`define CLK_IDX_FLAGS     4'h1
`define CLK_IDX_LBA0      4'h2
`define CLK_IDX_LBA3      4'h5
`define CLK_IDX_CNT0      4'h7
`define CLK_IDX_CNT1      4'h8
`define CLK_IDX_CTRL      4'h9
`define CLK_BIT_RELADR    0
`define CLK_BIT_LOCK      1
`define CLK_ST_GOOD       8'h00
`define CLK_ST_CHECK      8'h02
`endif

/* rtl/cache_lock_pkg.sv */
// Types for the cache lock/unlock command interpreter
package cache_lock_pkg;
  typedef struct packed {
    logic [7:0] byte_val;
    logic       first;
  } cdb_byte_t;

  typedef struct packed {
    logic [7:0] status;
    logic       done;
  } cmd_result_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_CHECK,
    ST_SCAN,
    ST_DONE
  } phase_t;
endpackage

/* rtl/cache_lock_unlock_cmd.sv */
// Cache lock/unlock (10) command interpreter with per-initiator lock tracking
`timescale 1ns/1ns
`include "cache_lock_defs.svh"

module cache_lock_unlock_cmd
  import cache_lock_pkg::*;
#(
  parameter int LINES     = 8,
  parameter int INITS     = 16,
  parameter int INIT_W    = 4,
  parameter int LINE_W    = 3
) (
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_in,
  input  wire cdb_byte_t                cdb_in,
  input  wire logic                     cdb_valid_in,
  input  wire logic [INIT_W-1:0]        initiator_in,
  input  wire logic                     linked_in,
  input  wire logic                     link_first_in,
  input  wire logic                     block_access_in,
  input  wire logic [31:0]              access_lba_in,
  input  wire logic [31:0]              last_lba_in,
  input  wire logic [LINES-1:0]         line_valid_in,
  input  wire logic [LINES-1:0][31:0]   line_lba_in,
  input  wire logic [LINES-1:0]         line_dirty_in,
  input  wire logic [LINES-1:0]         victim_req_in,
  output logic                          cmd_ready_out,
  output cmd_result_t                   result_out,
  output logic                          not_mine_out,
  output logic [LINES-1:0]              line_locked_out,
  output logic [LINES-1:0]              evict_allow_out,
  output logic [LINES-1:0]              writeback_keep_out
);

  typedef struct packed {
    phase_t                         phase;
    logic [3:0]                     idx;
    logic [7:0]                     opcode;
    logic                           lock;
    logic                           reladr;
    logic [31:0]                    lba;
    logic [15:0]                    count;
    logic [INIT_W-1:0]              init;
    logic [LINE_W:0]                line;
    logic [31:0]                    last_lba;
    logic                           last_ok;
    logic [LINES-1:0][INITS-1:0]    owner;
    cmd_result_t                    result;
    logic                           not_mine;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // Range membership of one cached block address
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] start,
                                    input logic [15:0] cnt);
    logic [32:0] top;
    top = {1'b0, start} + {17'h00000, cnt};
    if (cnt == 16'h0000)
      in_range = (a >= start);
    else
      in_range = (a >= start) && ({1'b0, a} < top);
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.result.done = 1'b0;
    s_next.not_mine = 1'b0;
    // Track last accessed block within the linked group
    if (!linked_in || link_first_in) begin
      s_next.last_ok = 1'b0;
    end
    if (block_access_in && linked_in) begin
      s_next.last_lba = access_lba_in;
      s_next.last_ok = 1'b1;
    end
    // Owners of a line that left the cache drop away
    for (int i = 0; i < LINES; i++) begin
      if (!line_valid_in[i])
        s_next.owner[i] = '0;
    end
    case (s_reg.phase)
      ST_IDLE: begin
        if (cdb_valid_in && cdb_in.first) begin
          s_next.opcode = cdb_in.byte_val;
          s_next.idx = 4'h1;
          s_next.init = initiator_in;
          s_next.phase = ST_RECV;
        end
      end
      ST_RECV: begin
        if (cdb_valid_in) begin
          if (s_reg.idx == `CLK_IDX_FLAGS) begin
            s_next.lock = cdb_in.byte_val[`CLK_BIT_LOCK];
            s_next.reladr = cdb_in.byte_val[`CLK_BIT_RELADR];
          end else if (s_reg.idx >= `CLK_IDX_LBA0 && s_reg.idx <= `CLK_IDX_LBA3) begin
            s_next.lba = {s_reg.lba[23:0], cdb_in.byte_val};
          end else if (s_reg.idx == `CLK_IDX_CNT0 || s_reg.idx == `CLK_IDX_CNT1) begin
            s_next.count = {s_reg.count[7:0], cdb_in.byte_val};
          end
          s_next.idx = s_reg.idx + 4'h1;
          if (s_reg.idx == `CLK_IDX_CTRL)
            s_next.phase = ST_CHECK;
        end
      end
      ST_CHECK: begin
        s_next.line = '0;
        if (s_reg.opcode != `CLK_OPCODE) begin
          s_next.not_mine = 1'b1;
          s_next.phase = ST_IDLE;
        end else if (s_reg.reladr) begin
          if (!linked_in || !s_reg.last_ok) begin
            s_next.result.status = `CLK_ST_CHECK;
            s_next.phase = ST_DONE;
          end else begin
            s_next.lba = s_reg.last_lba + s_reg.lba;
            s_next.phase = ST_SCAN;
          end
        end else begin
          s_next.phase = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (s_reg.line == LINES[LINE_W:0]) begin
          s_next.result.status = `CLK_ST_GOOD;
          s_next.phase = ST_DONE;
        end else begin
          if (line_valid_in[s_reg.line[LINE_W-1:0]] &&
              in_range(line_lba_in[s_reg.line[LINE_W-1:0]], s_reg.lba, s_reg.count)) begin
            // Only this initiator's ownership bit changes
            s_next.owner[s_reg.line[LINE_W-1:0]][s_reg.init] = s_reg.lock;
          end
          s_next.line = s_reg.line + 1'b1;
        end
      end
      ST_DONE: begin
        s_next.result.done = 1'b1;
        s_next.phase = ST_IDLE;
      end
      default: s_next.phase = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign cmd_ready_out = (s_reg.phase == ST_IDLE) || (s_reg.phase == ST_RECV);
  assign result_out = s_reg.result;
  assign not_mine_out = s_reg.not_mine;

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      assign line_locked_out[g] = |s_reg.owner[g];
      assign evict_allow_out[g] = victim_req_in[g] && !line_locked_out[g];
      assign writeback_keep_out[g] = line_dirty_in[g] && line_locked_out[g];
    end
  endgenerate

endmodule

/* verif/cache_lock_initiator.sv */
// Initiator model sending one command block per go pulse
`timescale 1ns/1ns
module cache_lock_initiator import cache_lock_pkg::*; (
  input  logic        clk_sys_in, go_in,
  input  logic [79:0] cmd_in,
  output cdb_byte_t   cdb_out = '0,
  output logic        valid_out
);
  logic [3:0] idx_reg = 4'h0;
  logic       send;
  assign valid_out = idx_reg != 4'h0;
  assign send = go_in || (valid_out && idx_reg != 4'ha);
  always @(posedge clk_sys_in) begin
    idx_reg <= send ? idx_reg + 4'h1 : 4'h0;
    cdb_out <= send ? {cmd_in[79 - 8 * int'(idx_reg) -: 8], !valid_out} : {~cdb_out.byte_val, 1'b0};
  end
endmodule

/* verif/cache_lock_monitor.sv */
// Port checks for the cache lock interpreter
`timescale 1ns/1ns
module cache_lock_monitor import cache_lock_pkg::*; #(parameter int LINES = 8) (
  input logic             clk_sys_in, rst_in, cmd_ready_out, not_mine_out,
  input cmd_result_t      result_out,
  input logic [LINES-1:0] line_valid_in, victim_req_in, line_locked_out, evict_allow_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  answer_due_a: assert property ($fell(cmd_ready_out) |-> ##[1:12] (result_out.done || not_mine_out))
    else $error("no answer");
  done_pulse_a: assert property (result_out.done |=> !result_out.done) else $error("done held");
  foreign_op_a: assert property (not_mine_out |-> !result_out.done ##1 !not_mine_out) else $error("foreign");
  status_code_a: assert property (result_out.done |-> result_out.status inside {8'h00, 8'h02})
    else $error("status");
  resident_only_a: assert property ((line_locked_out & ~$past(line_valid_in)) == '0) else $error("uncached");
  lock_in_scan_a: assert property ((line_locked_out & ~$past(line_locked_out)) != '0 |-> !$past(cmd_ready_out))
    else $error("stray lock");
  idle_hold_a: assert property (cmd_ready_out && $past(cmd_ready_out)
    && $past(line_valid_in) == $past(line_valid_in, 2) |-> $stable(line_locked_out)) else $error("lock moved");
  locked_kept_a: assert property (evict_allow_out == (victim_req_in & ~line_locked_out)) else $error("evicted");
  cover property (result_out.done && result_out.status == 8'h02);
  cover property (not_mine_out);
  cover property (line_locked_out != '0);
endmodule
bind cache_lock_unlock_cmd cache_lock_monitor #(.LINES(LINES)) mon (.clk_sys_in, .rst_in, .cmd_ready_out,
  .not_mine_out, .result_out, .line_valid_in, .victim_req_in, .line_locked_out, .evict_allow_out);

/* verif/cache_lock_unlock_cmd_tb_top.sv */
// Bench for the cache lock command interpreter
`timescale 1ns/1ns
module cache_lock_unlock_cmd_tb_top import cache_lock_pkg::*;;
  logic         clk_sys_in = 1'b0, rst_in = 1'b1, go = 1'b0, linked_in = 1'b0, block_access_in = 1'b0;
  logic         link_first = 1'b0;
  logic [7:0]   evict_allow_out;
  logic         cdb_valid_in, cmd_ready_out, not_mine_out;
  logic [3:0]   initiator_in = 4'h1;
  logic [7:0]   line_valid_in = 8'hf7, line_locked_out, writeback_keep_out;
  logic [79:0]  cmd = '0;
  logic [255:0] line_lba_in;
  cdb_byte_t    cdb_in;
  cmd_result_t  result_out;
  int           num_errors = 0, checks = 0;
  cache_lock_initiator host (.clk_sys_in, .go_in(go), .cmd_in(cmd), .cdb_out(cdb_in), .valid_out(cdb_valid_in));
  cache_lock_unlock_cmd dut (.clk_sys_in, .rst_in, .cdb_in, .cdb_valid_in, .initiator_in, .linked_in,
    .link_first_in(link_first), .block_access_in, .access_lba_in(32'h68), .last_lba_in(32'h0), .line_valid_in,
    .line_lba_in, .line_dirty_in(8'h0f), .victim_req_in(8'hff), .cmd_ready_out, .result_out, .not_mine_out,
    .line_locked_out, .evict_allow_out, .writeback_keep_out);
  initial forever #5 clk_sys_in = ~clk_sys_in;
  task automatic chk(input logic [17:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Sends one command, waits for its answer, compares status and locks
  task automatic run(input logic [3:0] who, input logic [47:0] head, input logic [15:0] cnt, input logic [17:0] exp);
    int i = 0;
    initiator_in <= who;
    cmd <= {head, 8'h00, cnt, 8'h00};
    go <= 1'b1;
    @(posedge clk_sys_in);
    go <= 1'b0;
    do begin
      @(negedge clk_sys_in);
      i++;
    end while (i < 40 && result_out.done !== 1'b1 && not_mine_out !== 1'b1);
    if (i == 40) begin
      num_errors++;
      report_and_stop();
    end
    chk({result_out, not_mine_out, line_locked_out}, exp);
    @(posedge clk_sys_in);
  endtask
  initial begin
    for (int k = 0; k < 8; k++)
      line_lba_in[32 * k +: 32] = 32'h64 + 32'(k);
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    run(4'h1, 48'h3602_0000_0064, 16'h4, 18'h00207);
    chk({10'h0, writeback_keep_out}, 18'h07);
    chk({10'h0, evict_allow_out}, 18'hf8);
    run(4'h2, 48'h3602_0000_0066, 16'h0, 18'h002f7);
    run(4'h1, 48'h3600_0000_0064, 16'h8, 18'h002f4);
    run(4'h1, 48'h3601_0000_0000, 16'h2, 18'h00af4);
    linked_in <= 1'b1;
    block_access_in <= 1'b1;
    @(posedge clk_sys_in);
    block_access_in <= 1'b0;
    run(4'h1, 48'h3603_ffff_fffc, 16'h2, 18'h002f7);
    run(4'h1, 48'h3502_0000_0064, 16'h8, 18'h001f7);
    // New linked group forgets the last accessed block
    link_first <= 1'b1;
    @(posedge clk_sys_in);
    link_first <= 1'b0;
    run(4'h1, 48'h3603_ffff_fffc, 16'h2, 18'h00af7);
    report_and_stop();
  end
endmodule
